// File: mtc_pkg_track.sv
// Shared constants of the memory traffic checker and its per-bit pass flag tracker
package mtc_pkg;
	localparam int MEM_W = 32;
	localparam int BURST_BEATS = 8;
	localparam int AVL_W = MEM_W * BURST_BEATS;
	localparam int ADDR_W = 27;
	localparam int NUM_WORDS = 16;
	localparam int LANE_W = 32;
	localparam int HALF_W = 16;
	localparam logic [15:0] LOOPS_RST = 16'h0001;
	localparam logic [7:0] BURST_WORDS = 8'h01;
	// Watchdog time in microseconds, rate in MHz
	localparam int TIMEOUT_US = 100;
	localparam int CLK_MHZ = 200;
	localparam int TIMEOUT_CYC = TIMEOUT_US * CLK_MHZ;
	localparam int CNT_W = 32;
	// Register byte addresses, spaced four apart
	localparam int REG_AW = 8;
	localparam logic [REG_AW-1:0] REG_CTRL = 8'h00;
	localparam logic [REG_AW-1:0] REG_STATUS = 8'h04;
	localparam logic [REG_AW-1:0] REG_INT_STAT = 8'h08;
	localparam logic [REG_AW-1:0] REG_INT_MASK = 8'h0C;
	localparam logic [REG_AW-1:0] REG_PERSIST0 = 8'h10;
	localparam int PERSIST_WORDS = AVL_W / 32;
	// Control fields
	localparam int CTRL_INF_BIT = 0;
	localparam int CTRL_LOOP_LSB = 16;
	// Status and interrupt bit positions
	localparam int EV_PASS = 0;
	localparam int EV_FAIL = 1;
	localparam int EV_TIMEOUT = 2;
	localparam int EV_N = 3;
	localparam int ST_BUSY = 3;
	localparam int ST_LOOP_LSB = 16;
	localparam logic [15:0] PAT_SEED = 16'hA5C3;
endpackage

module mtc_pnf_track #(
	parameter int MEM_W = mtc_pkg::MEM_W,
	parameter int BEATS = mtc_pkg::BURST_BEATS
) (
	input wire logic sys_clk_in,
	input wire logic arst_n_in,
	input wire logic clear_in,
	input wire logic check_in,
	input wire logic [MEM_W*BEATS-1:0] actual_in,
	input wire logic [MEM_W*BEATS-1:0] expect_in,
	output logic [MEM_W*BEATS-1:0] pnf_out,
	output logic [MEM_W*BEATS-1:0] persist_out
);
	logic [MEM_W*BEATS-1:0] pnf_d;
	logic [MEM_W*BEATS-1:0] persist_d;

	// Flag k is data bit k mod MEM_W of beat k div MEM_W
	for (genvar b = 0; b < BEATS; b++) begin : g_beat
		always_comb begin
			if (check_in) begin
				pnf_d[b*MEM_W +: MEM_W] = ~(actual_in[b*MEM_W +: MEM_W] ^ expect_in[b*MEM_W +: MEM_W]);
			end else begin
				pnf_d[b*MEM_W +: MEM_W] = '1;
			end
			if (clear_in) begin
				persist_d[b*MEM_W +: MEM_W] = '1;
			end else begin
				persist_d[b*MEM_W +: MEM_W] = persist_out[b*MEM_W +: MEM_W] & pnf_d[b*MEM_W +: MEM_W];
			end
		end
	end

	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			pnf_out <= '1;
			persist_out <= '1;
		end else begin
			pnf_out <= clear_in ? '1 : pnf_d;
			persist_out <= persist_d;
		end
	end
endmodule

// File: mtc_traffic_checker.sv
// Memory traffic generator and checker: bus master, pass/fail/timeout and registers
// Overview of operation
// - One pass flag per bus data bit
// - Flag low only on mismatching transfers
// - Persistent flag follows, then stays low
// - Each access is a one-word burst, eight beats wide
// - Flag k is bit k mod width, beat k/width
// - Pass needs no errors and all loops done
// - Infinite duration never asserts pass
// - Fail rises when any flag drops
// - Timeout rises when transfers stall too long
// - One iteration by default, continuous optional
module mtc_traffic_checker #(
	parameter int AVL_W = mtc_pkg::AVL_W,
	parameter int MEM_W = mtc_pkg::MEM_W,
	parameter int ADDR_W = mtc_pkg::ADDR_W,
	parameter int NUM_WORDS = mtc_pkg::NUM_WORDS,
	parameter int TIMEOUT_CYCLES = mtc_pkg::TIMEOUT_CYC,
	parameter bit TEST_INFINITE = 1'b0
) (
	input wire logic sys_clk_in,
	input wire logic arst_n_in,
	input wire logic generator_restart_in,
	output logic amm_read_out,
	output logic amm_write_out,
	output logic [ADDR_W-1:0] amm_address_out,
	output logic [7:0] amm_burstcount_out,
	output logic [AVL_W/8-1:0] amm_byteenable_out,
	output logic [AVL_W-1:0] amm_writedata_out,
	input wire logic amm_ready_in,
	input wire logic amm_readdatavalid_in,
	input wire logic [AVL_W-1:0] amm_readdata_in,
	output logic [AVL_W-1:0] pnf_per_bit_out,
	output logic [AVL_W-1:0] pnf_per_bit_persist_out,
	output logic traffic_gen_pass_out,
	output logic traffic_gen_fail_out,
	output logic traffic_gen_timeout_out,
	input wire logic [mtc_pkg::REG_AW-1:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_write_in,
	input wire logic reg_read_in,
	output logic [31:0] reg_rdata_out,
	output logic irq_out
);
	typedef enum logic [5:0] {
		MTC_IDLE = 6'h01,
		MTC_WRITE = 6'h02,
		MTC_READ = 6'h04,
		MTC_WAIT = 6'h08,
		MTC_DONE = 6'h10,
		MTC_STOP = 6'h20
	} mtc_state_type;

	localparam int WC_W = $clog2(NUM_WORDS + 1);
	localparam logic [WC_W-1:0] WORDS_LAST = WC_W'(NUM_WORDS);
	localparam logic [mtc_pkg::CNT_W-1:0] TO_LIMIT = mtc_pkg::CNT_W'(TIMEOUT_CYCLES);

	// Test pattern per word; shared by writer and checker
	function automatic logic [AVL_W-1:0] mtc_pattern(input logic [WC_W-1:0] word,
			input logic [15:0] loop);
		logic [AVL_W-1:0] r;
		logic [15:0] w16;
		r = '0;
		w16 = 16'(word);
		for (int j = 0; j < AVL_W / mtc_pkg::LANE_W; j++) begin
			r[j*mtc_pkg::LANE_W +: mtc_pkg::LANE_W] = {loop ^ mtc_pkg::PAT_SEED, w16 + 16'(j)};
		end
		return r;
	endfunction

	mtc_state_type state_q, state_d;
	logic wr_q, wr_d, rd_q, rd_d;
	logic [ADDR_W-1:0] addr_q, addr_d;
	logic [AVL_W-1:0] wdata_q, wdata_d;
	logic [WC_W-1:0] issued_q, issued_d, ret_q, ret_d;
	logic [15:0] loop_q, loop_d;
	logic [mtc_pkg::CNT_W-1:0] to_cnt_q, to_cnt_d;
	logic pass_q, pass_d, fail_q, fail_d, tout_q, tout_d;
	logic accept, cmd_free, progress, check_valid;
	logic [AVL_W-1:0] expect_data;

	// Control and interrupt registers
	logic inf_q, inf_d;
	logic [15:0] loops_q, loops_d;
	logic [mtc_pkg::EV_N-1:0] stat_q, stat_d, mask_q, mask_d, events;
	logic [31:0] rdata_q, rdata_d;
	logic irq_q, irq_d;
	logic [31:0] status_word;

	assign accept = (wr_q | rd_q) & amm_ready_in;
	assign cmd_free = ~(wr_q | rd_q) | accept;
	assign check_valid = amm_readdatavalid_in & (state_q == MTC_READ || state_q == MTC_WAIT);
	assign progress = accept | amm_readdatavalid_in;
	assign expect_data = mtc_pattern(ret_q, loop_q);

	mtc_pnf_track #(
		.MEM_W(MEM_W),
		.BEATS(AVL_W / MEM_W)
	) u_track (
		.sys_clk_in(sys_clk_in),
		.arst_n_in(arst_n_in),
		.clear_in(generator_restart_in | state_q == MTC_IDLE),
		.check_in(check_valid),
		.actual_in(amm_readdata_in),
		.expect_in(expect_data),
		.pnf_out(pnf_per_bit_out),
		.persist_out(pnf_per_bit_persist_out)
	);

	always_comb begin
		state_d = state_q;
		wr_d = wr_q;
		rd_d = rd_q;
		addr_d = addr_q;
		wdata_d = wdata_q;
		issued_d = issued_q;
		ret_d = ret_q;
		loop_d = loop_q;
		to_cnt_d = to_cnt_q;
		pass_d = pass_q;
		tout_d = tout_q;
		fail_d = fail_q | ~(&pnf_per_bit_out);
		if (check_valid) begin
			ret_d = ret_q + 1'b1;
		end
		if (state_q == MTC_WRITE || state_q == MTC_READ || state_q == MTC_WAIT) begin
			to_cnt_d = progress ? '0 : to_cnt_q + 1'b1;
		end
		case (state_q)
			MTC_IDLE: begin
				wr_d = 1'b0;
				rd_d = 1'b0;
				issued_d = '0;
				ret_d = '0;
				loop_d = '0;
				to_cnt_d = '0;
				pass_d = 1'b0;
				fail_d = 1'b0;
				tout_d = 1'b0;
				state_d = MTC_WRITE;
			end
			MTC_WRITE: begin
				if (cmd_free) begin
					if (issued_q == WORDS_LAST) begin
						wr_d = 1'b0;
						issued_d = '0;
						state_d = MTC_READ;
					end else begin
						wr_d = 1'b1;
						addr_d = ADDR_W'(issued_q);
						wdata_d = mtc_pattern(issued_q, loop_q);
						issued_d = issued_q + 1'b1;
					end
				end
			end
			MTC_READ: begin
				if (cmd_free) begin
					if (issued_q == WORDS_LAST) begin
						rd_d = 1'b0;
						state_d = MTC_WAIT;
					end else begin
						rd_d = 1'b1;
						addr_d = ADDR_W'(issued_q);
						issued_d = issued_q + 1'b1;
					end
				end
			end
			MTC_WAIT: begin
				if (ret_q == WORDS_LAST) begin
					issued_d = '0;
					ret_d = '0;
					loop_d = loop_q + 1'b1;
					if (!inf_q && (loop_q + 1'b1) >= loops_q) begin
						state_d = MTC_DONE;
					end else begin
						state_d = MTC_WRITE;
					end
				end
			end
			MTC_DONE: begin
				pass_d = ~fail_q & ~inf_q;
			end
			MTC_STOP: begin
				wr_d = 1'b0;
				rd_d = 1'b0;
			end
			default: begin
				state_d = MTC_IDLE;
			end
		endcase
		if (to_cnt_q >= TO_LIMIT && state_q != MTC_STOP) begin
			tout_d = 1'b1;
			wr_d = 1'b0;
			rd_d = 1'b0;
			state_d = MTC_STOP;
		end
		if (generator_restart_in) begin
			state_d = MTC_IDLE;
			// A spent watchdog count would stop the rerun in its first cycle
			to_cnt_d = '0;
			wr_d = 1'b0;
			rd_d = 1'b0;
			pass_d = 1'b0;
			fail_d = 1'b0;
			tout_d = 1'b0;
		end
	end

	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state_q <= MTC_IDLE;
			wr_q <= 1'b0;
			rd_q <= 1'b0;
			addr_q <= '0;
			wdata_q <= '0;
			issued_q <= '0;
			ret_q <= '0;
			loop_q <= '0;
			to_cnt_q <= '0;
			pass_q <= 1'b0;
			fail_q <= 1'b0;
			tout_q <= 1'b0;
		end else begin
			state_q <= state_d;
			wr_q <= wr_d;
			rd_q <= rd_d;
			addr_q <= addr_d;
			wdata_q <= wdata_d;
			issued_q <= issued_d;
			ret_q <= ret_d;
			loop_q <= loop_d;
			to_cnt_q <= to_cnt_d;
			pass_q <= pass_d;
			fail_q <= fail_d;
			tout_q <= tout_d;
		end
	end

	assign amm_read_out = rd_q;
	assign amm_write_out = wr_q;
	assign amm_address_out = addr_q;
	assign amm_writedata_out = wdata_q;
	assign amm_burstcount_out = mtc_pkg::BURST_WORDS;
	assign amm_byteenable_out = '1;
	assign traffic_gen_pass_out = pass_q;
	assign traffic_gen_fail_out = fail_q;
	assign traffic_gen_timeout_out = tout_q;

	// Register file
	always_comb begin
		status_word = '0;
		status_word[mtc_pkg::EV_PASS] = pass_q;
		status_word[mtc_pkg::EV_FAIL] = fail_q;
		status_word[mtc_pkg::EV_TIMEOUT] = tout_q;
		status_word[mtc_pkg::ST_BUSY] = state_q == MTC_WRITE || state_q == MTC_READ
			|| state_q == MTC_WAIT;
		status_word[mtc_pkg::ST_LOOP_LSB +: 16] = loop_q;
		events = '0;
		events[mtc_pkg::EV_PASS] = pass_d & ~pass_q;
		events[mtc_pkg::EV_FAIL] = fail_d & ~fail_q;
		events[mtc_pkg::EV_TIMEOUT] = tout_d & ~tout_q;
		inf_d = inf_q;
		loops_d = loops_q;
		mask_d = mask_q;
		stat_d = stat_q;
		rdata_d = '0;
		if (reg_write_in) begin
			case (reg_addr_in)
				mtc_pkg::REG_CTRL: begin
					inf_d = reg_wdata_in[mtc_pkg::CTRL_INF_BIT];
					loops_d = reg_wdata_in[mtc_pkg::CTRL_LOOP_LSB +: 16];
				end
				mtc_pkg::REG_INT_STAT: begin
					stat_d = stat_q & ~reg_wdata_in[mtc_pkg::EV_N-1:0];
				end
				mtc_pkg::REG_INT_MASK: begin
					mask_d = reg_wdata_in[mtc_pkg::EV_N-1:0];
				end
				default: begin
				end
			endcase
		end
		// A new event wins over a clear in the same cycle
		stat_d = stat_d | events;
		if (reg_read_in) begin
			case (reg_addr_in)
				mtc_pkg::REG_CTRL: begin
					rdata_d[mtc_pkg::CTRL_INF_BIT] = inf_q;
					rdata_d[mtc_pkg::CTRL_LOOP_LSB +: 16] = loops_q;
				end
				mtc_pkg::REG_STATUS: begin
					rdata_d = status_word;
				end
				mtc_pkg::REG_INT_STAT: begin
					rdata_d[mtc_pkg::EV_N-1:0] = stat_q;
				end
				mtc_pkg::REG_INT_MASK: begin
					rdata_d[mtc_pkg::EV_N-1:0] = mask_q;
				end
				default: begin
					for (int w = 0; w < mtc_pkg::PERSIST_WORDS; w++) begin
						if (reg_addr_in == mtc_pkg::REG_PERSIST0 + mtc_pkg::REG_AW'(4 * w)) begin
							rdata_d = pnf_per_bit_persist_out[w*32 +: 32];
						end
					end
				end
			endcase
		end
		irq_d = |(stat_d & mask_d);
	end

	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			inf_q <= TEST_INFINITE;
			loops_q <= mtc_pkg::LOOPS_RST;
			mask_q <= '0;
			stat_q <= '0;
			rdata_q <= '0;
			irq_q <= 1'b0;
		end else begin
			inf_q <= inf_d;
			loops_q <= loops_d;
			mask_q <= mask_d;
			stat_q <= stat_d;
			rdata_q <= rdata_d;
			irq_q <= irq_d;
		end
	end

	assign reg_rdata_out = rdata_q;
	assign irq_out = irq_q;
endmodule

// File: mtc_traffic_checker_properties.sv
// Assertions bound to the traffic checker's ports
module mtc_chk (
	input wire logic sys_clk_in,
	input wire logic arst_n_in,
	input wire logic generator_restart_in,
	input wire logic amm_read_out,
	input wire logic amm_write_out,
	input wire logic [26:0] amm_address_out,
	input wire logic amm_ready_in,
	input wire logic [255:0] pnf_per_bit_out,
	input wire logic [255:0] pnf_per_bit_persist_out,
	input wire logic traffic_gen_pass_out,
	input wire logic traffic_gen_fail_out,
	input wire logic traffic_gen_timeout_out
);
	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (!arst_n_in);
	sequence clr_s;
		!traffic_gen_pass_out && !traffic_gen_fail_out && &pnf_per_bit_persist_out;
	endsequence
	sequence bad_s;
		!generator_restart_in && !(&pnf_per_bit_out);
	endsequence
	sequence rerun_s;
		generator_restart_in ##1 !generator_restart_in;
	endsequence
	rerun_fresh_a: assert property (rerun_s |=> !traffic_gen_timeout_out)
		else $error("timeout right after restart");
	restart_clear_a: assert property (generator_restart_in |=> clr_s)
		else $error("restart left status");
	rw_excl_a: assert property (!(amm_read_out && amm_write_out))
		else $error("read with write");
	wr_hold_a: assert property (amm_write_out && !amm_ready_in && !generator_restart_in |=>
		traffic_gen_timeout_out || amm_write_out && $stable(amm_address_out))
		else $error("write dropped");
	rd_hold_a: assert property (amm_read_out && !amm_ready_in && !generator_restart_in |=>
		traffic_gen_timeout_out || amm_read_out && $stable(amm_address_out))
		else $error("read dropped");
	persist_keep_a: assert property (!generator_restart_in |=>
		(pnf_per_bit_persist_out & ~$past(pnf_per_bit_persist_out)) == '0)
		else $error("persist flag rose");
	persist_follow_a: assert property (bad_s |=>
		(pnf_per_bit_persist_out & ~$past(pnf_per_bit_out)) == '0)
		else $error("persist missed drop");
	fail_on_flag_a: assert property (bad_s |=> traffic_gen_fail_out)
		else $error("fail late");
	fail_hold_a: assert property (traffic_gen_fail_out && !generator_restart_in |=> traffic_gen_fail_out)
		else $error("fail fell");
	pass_clean_a: assert property ($rose(traffic_gen_pass_out) |->
		!traffic_gen_fail_out && &pnf_per_bit_persist_out)
		else $error("pass with errors");
endmodule

bind mtc_traffic_checker mtc_chk u_mtc_chk (
	.sys_clk_in(sys_clk_in),
	.arst_n_in(arst_n_in),
	.generator_restart_in(generator_restart_in),
	.amm_read_out(amm_read_out),
	.amm_write_out(amm_write_out),
	.amm_address_out(amm_address_out),
	.amm_ready_in(amm_ready_in),
	.pnf_per_bit_out(pnf_per_bit_out),
	.pnf_per_bit_persist_out(pnf_per_bit_persist_out),
	.traffic_gen_pass_out(traffic_gen_pass_out),
	.traffic_gen_fail_out(traffic_gen_fail_out),
	.traffic_gen_timeout_out(traffic_gen_timeout_out)
);

// File: mtc_mem_model.sv
// Behavioural memory controller user port facing the traffic checker
module mtc_mem_model (
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire logic stall_in,
	input wire logic [255:0] flip_in,
	input wire logic read_in,
	input wire logic write_in,
	input wire logic [26:0] address_in,
	input wire logic [255:0] writedata_in,
	output logic ready_out,
	output logic readdatavalid_out,
	output logic [255:0] readdata_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [255:0] mem [16];
	assign ready_out = !stall_in;
	always @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			readdatavalid_out <= 1'b0;
			readdata_out <= '0;
		end else begin
			readdatavalid_out <= read_in && ready_out;
			if (write_in && ready_out)
				mem[address_in[3:0]] <= writedata_in;
			// Flip mask corrupts returned bits; idle data is scrambled
			if (read_in && ready_out)
				readdata_out <= mem[address_in[3:0]] ^ flip_in;
			else
				readdata_out <= ~readdata_out;
		end
	end
endmodule

// File: mtc_traffic_checker_tb.sv
// Self-checking bench for the memory traffic checker
module mtc_traffic_checker_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic restart = 1'b0;
	logic stall = 1'b0;
	logic stall_hold = 1'b0;
	logic choppy = 1'b0;
	logic [255:0] flip = '0;
	logic rd, wr, rdy, rdv, pass, fail, tmo, irq;
	logic [26:0] addr;
	logic [7:0] bcnt;
	logic [31:0] ben, rdata;
	logic [255:0] wdat, rdat, pnf, pers;
	logic [7:0] ra = '0;
	logic [31:0] wd = '0;
	logic rw = 1'b0;
	logic rr = 1'b0;
	int n_errors = 0;
	int total_checks = 0;
	always #2.5 clk = ~clk;
	always @(posedge clk) stall <= choppy ? ~stall : stall_hold;
	mtc_traffic_checker #(.TIMEOUT_CYCLES(50)) u_mtc_traffic_checker (
		.sys_clk_in(clk), .arst_n_in(rst_n), .generator_restart_in(restart),
		.amm_read_out(rd), .amm_write_out(wr), .amm_address_out(addr),
		.amm_burstcount_out(bcnt), .amm_byteenable_out(ben), .amm_writedata_out(wdat),
		.amm_ready_in(rdy), .amm_readdatavalid_in(rdv), .amm_readdata_in(rdat),
		.pnf_per_bit_out(pnf), .pnf_per_bit_persist_out(pers), .traffic_gen_pass_out(pass),
		.traffic_gen_fail_out(fail), .traffic_gen_timeout_out(tmo), .reg_addr_in(ra),
		.reg_wdata_in(wd), .reg_write_in(rw), .reg_read_in(rr), .reg_rdata_out(rdata),
		.irq_out(irq));
	mtc_mem_model u_mtc_mem_model (.clk_in(clk), .arst_n_in(rst_n), .stall_in(stall),
		.flip_in(flip), .read_in(rd), .write_in(wr), .address_in(addr), .writedata_in(wdat),
		.ready_out(rdy), .readdatavalid_out(rdv), .readdata_out(rdat));
	task automatic chk(input string what, input logic [255:0] seen, input logic [255:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		ra <= a;
		wd <= d;
		rw <= 1'b1;
		@(posedge clk);
		rw <= 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		ra <= a;
		rr <= 1'b1;
		@(posedge clk);
		rr <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic wait_for(input int sel, input int bound);
		for (int i = 0; i < bound; i++) begin
			@(posedge clk);
			#1;
			if (sel == 0 && pass === 1'b1 || sel == 1 && fail === 1'b1 || sel == 2 && tmo === 1'b1)
				return;
		end
		chk("wait bound", 1'b1, 1'b0);
		report_and_stop();
	endtask
	task automatic do_restart();
		@(posedge clk);
		restart <= 1'b1;
		@(posedge clk);
		restart <= 1'b0;
		#1;
		chk("restart fail", fail, 1'b0);
	endtask
	task automatic t_single_pass();
		logic [31:0] d;
		wr_reg(mtc_pkg::REG_INT_MASK, 32'h0000_0001);
		choppy <= 1'b1;
		wait_for(0, 3000);
		chk("burst shape", {bcnt, ben}, {8'h01, 32'hFFFF_FFFF});
		chk("pass persist", pers, {256{1'b1}});
		chk("pattern", u_mtc_mem_model.mem[5][63:0], {mtc_pkg::PAT_SEED, 16'h0006, mtc_pkg::PAT_SEED, 16'h0005});
		rd_reg(mtc_pkg::REG_STATUS, d);
		chk("status", d, 32'h0001_0001);
		repeat (40) @(posedge clk);
		#1;
		chk("idle after one run", {rd, wr, irq}, 3'b001);
		wr_reg(mtc_pkg::REG_INT_STAT, 32'h0000_0001);
		repeat (3) @(posedge clk);
		#1;
		chk("irq cleared", irq, 1'b0);
		$display("single pass test done");
	endtask
	task automatic t_bit_errors();
		logic [31:0] d;
		flip <= (256'h1 << 32) | (256'h1 << 255);
		do_restart();
		wait_for(1, 3000);
		repeat (200) @(posedge clk);
		#1;
		chk("persist", pers, ~((256'h1 << 32) | (256'h1 << 255)));
		chk("transient", pnf, {256{1'b1}});
		chk("flags", {pass, fail}, 2'b01);
		rd_reg(mtc_pkg::REG_PERSIST0 + 8'h04, d);
		chk("persist word1", d, 32'hFFFF_FFFE);
		choppy <= 1'b0;
		$display("bit error test done");
	endtask
	task automatic t_timeout();
		flip <= '0;
		stall_hold <= 1'b1;
		do_restart();
		wait_for(2, 200);
		chk("timeout pass", {rd, wr, pass}, 3'b000);
		stall_hold <= 1'b0;
		$display("timeout test done");
	endtask
	task automatic t_loops();
		logic [31:0] d;
		wr_reg(mtc_pkg::REG_CTRL, 32'h0001_0001);
		do_restart();
		for (int i = 0; i < 600; i++) begin
			@(posedge clk);
			#1;
			if (pass !== 1'b0)
				chk("infinite pass", pass, 1'b0);
		end
		rd_reg(mtc_pkg::REG_STATUS, d);
		chk("loops run", d[31:16] >= 16'h0002, 1'b1);
		wr_reg(mtc_pkg::REG_CTRL, 32'h0003_0000);
		do_restart();
		wait_for(0, 3000);
		rd_reg(mtc_pkg::REG_STATUS, d);
		chk("three loops", d[31:16], 16'h0003);
		rd_reg(8'hF0, d);
		chk("unmapped", d, 32'h0);
		$display("loop count test done");
	endtask
	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		t_single_pass();
		t_bit_errors();
		t_timeout();
		t_loops();
		report_and_stop();
	end
endmodule
